// >>> dcf_fifo.sv
`timescale 1ns/1ps
`include "dcf_regs.svh"
`default_nettype none

module dcf_fifo (
    input  wire logic                   ref_clk_i,
    input  wire logic                   rstn_i,
    input  wire logic                   write_clk_i,
    input  wire logic                   read_clk_i,
    input  wire logic                   write_enable_n_i,
    input  wire logic                   read_enable_n_i,
    input  wire logic                   serial_enable_n_i,
    input  wire logic                   offset_load_n_i,
    input  wire logic                   fallthrough_select_serial_in_i,
    input  wire logic                   full_init_n_i,
    input  wire logic                   partial_init_n_i,
    input  wire logic                   replay_request_n_i,
    input  wire logic                   output_enable_n_i,
    input  wire logic [`DCF_DATA_W-1:0] write_data_in_i,
    output logic      [`DCF_DATA_W-1:0] read_data_out_o,
    output logic                        read_data_out_oe_o,
    output logic                        full_or_input_ready_o,
    output logic                        empty_or_output_ready_o,
    output logic                        almost_full_n_o,
    output logic                        almost_empty_n_o,
    output logic                        half_full_n_o
);

    // every pin but rstn_i is asynchronous to ref_clk, so all those pass two flops
    logic [`DCF_SYNC_W-1:0] raw;
    logic [`DCF_SYNC_W-1:0] sync1_q;
    logic [`DCF_SYNC_W-1:0] sync2_q;

    assign raw = {write_clk_i, read_clk_i, write_enable_n_i, read_enable_n_i,
                  serial_enable_n_i, offset_load_n_i,
                  fallthrough_select_serial_in_i, full_init_n_i,
                  partial_init_n_i, replay_request_n_i, output_enable_n_i,
                  write_data_in_i};

    localparam logic [`DCF_SYNC_W-1:0] SYNC_RST = `DCF_SYNC_RST;

    genvar gi;
    generate
        for (gi = 0; gi < `DCF_SYNC_W; gi++) begin : g_sync
            always_ff @(posedge ref_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    sync1_q[gi] <= SYNC_RST[gi];
                    sync2_q[gi] <= SYNC_RST[gi];
                end else begin
                    sync1_q[gi] <= raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    logic                   wclk_s;
    logic                   rclk_s;
    logic                   wen_n_s;
    logic                   ren_n_s;
    logic                   sen_n_s;
    logic                   ld_n_s;
    logic                   si_s;
    logic                   mrs_n_s;
    logic                   prs_n_s;
    logic                   rt_n_s;
    logic                   oe_n_s;
    logic [`DCF_DATA_W-1:0] din_s;

    assign {wclk_s, rclk_s, wen_n_s, ren_n_s, sen_n_s, ld_n_s, si_s, mrs_n_s,
            prs_n_s, rt_n_s, oe_n_s, din_s} = sync2_q;

    // edge detection of the sampled pin clocks
    logic wclk_d_q;
    logic rclk_d_q;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wclk_d_q <= 1'b0;
            rclk_d_q <= 1'b0;
        end else begin
            wclk_d_q <= wclk_s;
            rclk_d_q <= rclk_s;
        end
    end

    logic w_edge;
    logic r_edge;
    logic r_trans;
    logic init;

    assign w_edge  = wclk_s & ~wclk_d_q;
    assign r_edge  = rclk_s & ~rclk_d_q;
    assign r_trans = rclk_s ^ rclk_d_q;
    assign init    = ~mrs_n_s | ~prs_n_s;

    // configuration latched during full init
    dcf_pkg::dcf_mode_e mode_q;
    dcf_pkg::dcf_prog_e prog_q;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_q <= dcf_pkg::DCF_STANDARD;
            prog_q <= dcf_pkg::DCF_PARALLEL;
        end else if (!mrs_n_s) begin
            mode_q <= dcf_pkg::dcf_mode_e'(si_s);
            prog_q <= dcf_pkg::dcf_prog_e'(ld_n_s);
        end
    end

    logic fallthrough_mode;
    assign fallthrough_mode = (mode_q == dcf_pkg::DCF_FALLTHROUGH);

    // pointers carry a wrap bit so full and empty differ
    logic [`DCF_PTR_W-1:0] wr_ptr_q;
    logic [`DCF_PTR_W-1:0] rd_ptr_q;
    logic [`DCF_PTR_W-1:0] count;
    logic                  mem_empty;
    logic                  mem_full;

    assign count     = wr_ptr_q - rd_ptr_q;
    assign mem_empty = (count == '0);
    assign mem_full  = (count == `DCF_DEPTH);

    logic out_valid_q;
    logic [1:0] fall_cnt_q;
    logic replay;
    logic rd_req;
    logic off_rd_go;
    logic wr_go;
    logic std_go;
    logic adv_go;
    logic fall_go;
    logic load_go;
    logic drain;

    assign replay    = r_edge & ~rt_n_s & ~init;
    assign rd_req    = r_edge & ~ren_n_s & ld_n_s & ~init & ~replay;
    assign off_rd_go = r_edge & ~ren_n_s & ~ld_n_s & ~init;
    assign wr_go     = w_edge & ~wen_n_s & ld_n_s & ~mem_full & ~init;
    assign std_go    = ~fallthrough_mode & rd_req & ~mem_empty;
    assign adv_go    = fallthrough_mode & rd_req & out_valid_q & ~mem_empty;
    assign drain     = fallthrough_mode & rd_req & out_valid_q & mem_empty;
    assign fall_go   = fallthrough_mode & ~out_valid_q & ~mem_empty & ~init & ~replay
                     & r_trans & (fall_cnt_q == `DCF_FALL_TRANS - 2'h1);
    assign load_go   = std_go | adv_go | fall_go;

    logic [`DCF_DATA_W-1:0] mem [0:`DCF_DEPTH-1];

    always_ff @(posedge ref_clk_i) begin
        if (wr_go) begin
            mem[wr_ptr_q[`DCF_ADDR_W-1:0]] <= din_s;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr_q <= '0;
        end else if (init) begin
            wr_ptr_q <= '0;
        end else if (wr_go) begin
            wr_ptr_q <= wr_ptr_q + 17'h1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_ptr_q <= '0;
        end else if (init || replay) begin
            rd_ptr_q <= '0;
        end else if (load_go) begin
            rd_ptr_q <= rd_ptr_q + 17'h1;
        end
    end

    // counts read-clock transitions while a word waits to fall through
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fall_cnt_q <= 2'h0;
        end else if (init || replay || out_valid_q || mem_empty || fall_go) begin
            fall_cnt_q <= 2'h0;
        end else if (r_trans) begin
            fall_cnt_q <= fall_cnt_q + 2'h1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_valid_q <= 1'b0;
        end else if (init || replay || drain) begin
            out_valid_q <= 1'b0;
        end else if (fall_go) begin
            out_valid_q <= 1'b1;
        end
    end

    // offsets: empty in the low half, full in the high half
    logic [2*`DCF_OFF_W-1:0] off_q;
    logic [1:0]              pwr_idx_q;
    logic [1:0]              prd_idx_q;
    logic [4:0]              ser_idx_q;
    logic                    par_wr;
    logic                    ser_wr;
    logic [`DCF_OFF_W-1:0]   off_dflt;

    assign par_wr   = w_edge & ~wen_n_s & ~ld_n_s & ~init
                    & (prog_q == dcf_pkg::DCF_PARALLEL);
    assign ser_wr   = w_edge & ~sen_n_s & ~ld_n_s & ~init
                    & (prog_q == dcf_pkg::DCF_SERIAL);
    assign off_dflt = ld_n_s ? `DCF_OFF_HIGH : `DCF_OFF_LOW;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            off_q <= {`DCF_OFF_LOW, `DCF_OFF_LOW};
        end else if (!mrs_n_s) begin
            off_q <= {off_dflt, off_dflt};
        end else if (ser_wr) begin
            off_q[ser_idx_q] <= si_s;
        end else if (par_wr) begin
            case (pwr_idx_q)
                2'h0: off_q[8:0]   <= din_s;
                2'h1: off_q[15:9]  <= din_s[6:0];
                2'h2: off_q[24:16] <= din_s;
                2'h3: off_q[31:25] <= din_s[6:0];
                default: off_q <= off_q;
            endcase
        end
    end

    // sequence indices restart whenever offset-load is released
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pwr_idx_q <= 2'h0;
            prd_idx_q <= 2'h0;
            ser_idx_q <= 5'h0;
        end else if (init || ld_n_s) begin
            pwr_idx_q <= 2'h0;
            prd_idx_q <= 2'h0;
            ser_idx_q <= 5'h0;
        end else begin
            if (par_wr) begin
                pwr_idx_q <= pwr_idx_q + 2'h1;
            end
            if (ser_wr) begin
                ser_idx_q <= ser_idx_q + 5'h1;
            end
            if (off_rd_go) begin
                prd_idx_q <= prd_idx_q + 2'h1;
            end
        end
    end

    logic [`DCF_DATA_W-1:0] off_part;

    always_comb begin
        case (prd_idx_q)
            2'h0:    off_part = off_q[8:0];
            2'h1:    off_part = {2'h0, off_q[15:9]};
            2'h2:    off_part = off_q[24:16];
            2'h3:    off_part = {2'h0, off_q[31:25]};
            default: off_part = '0;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            read_data_out_o <= '0;
        end else if (init) begin
            read_data_out_o <= '0;
        end else if (load_go) begin
            read_data_out_o <= mem[rd_ptr_q[`DCF_ADDR_W-1:0]];
        end else if (off_rd_go) begin
            read_data_out_o <= off_part;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            read_data_out_oe_o <= 1'b0;
        end else begin
            read_data_out_oe_o <= ~oe_n_s;
        end
    end

    // standard-mode empty is held low after a replay until the next read edge
    logic blank_q;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            blank_q <= 1'b0;
        end else if (replay) begin
            blank_q <= 1'b1;
        end else if (r_edge || init) begin
            blank_q <= 1'b0;
        end
    end

    logic [`DCF_PTR_W-1:0] full_thr;
    assign full_thr = `DCF_DEPTH - {1'b0, off_q[31:16]};

    // fall-through capacity counts memory only; the output register is extra
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            full_or_input_ready_o <= 1'b1;
        end else if (fallthrough_mode) begin
            full_or_input_ready_o <= mem_full;
        end else begin
            full_or_input_ready_o <= ~mem_full;
        end
    end

    // replay forces the not-ready level at the ref_clk edge right after it is seen, so a
    // reader never trusts a word from before the rewind
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            empty_or_output_ready_o <= 1'b0;
        end else if (fallthrough_mode) begin
            empty_or_output_ready_o <= ~out_valid_q | replay;
        end else begin
            empty_or_output_ready_o <= ~(mem_empty | blank_q | replay);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            almost_full_n_o <= 1'b1;
        end else begin
            almost_full_n_o <= ~(count > full_thr);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            almost_empty_n_o <= 1'b0;
        end else begin
            almost_empty_n_o <= ~(count < {1'b0, off_q[15:0]});
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            half_full_n_o <= 1'b1;
        end else begin
            half_full_n_o <= ~(count > `DCF_HALF);
        end
    end

endmodule : dcf_fifo

`default_nettype wire

// >>> dcf_fifo_sva.sv
`timescale 1ns/1ps
`include "dcf_regs.svh"
`default_nettype none

module dcf_fifo_chk (
    input wire logic                   ref_clk_i,
    input wire logic                   rstn_i,
    input wire logic                   write_clk_i,
    input wire logic                   read_clk_i,
    input wire logic                   full_init_n_i,
    input wire logic                   partial_init_n_i,
    input wire logic                   output_enable_n_i,
    input wire logic                   fallthrough_select_serial_in_i,
    input wire logic [`DCF_DATA_W-1:0] read_data_out_o,
    input wire logic                   read_data_out_oe_o,
    input wire logic                   full_or_input_ready_o,
    input wire logic                   empty_or_output_ready_o,
    input wire logic                   almost_full_n_o,
    input wire logic                   almost_empty_n_o,
    input wire logic                   half_full_n_o
);
    logic       mode_q;
    logic [2:0] calm_q;

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    // mode taken straight from the pin; the design's copy trails by its sync delay
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i)
            mode_q <= 1'b0;
        else if (!full_init_n_i)
            mode_q <= fallthrough_select_serial_in_i;
    end

    // flag meaning flips at full init, so wait until that has settled
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i || !full_init_n_i)
            calm_q <= 3'h0;
        else if (calm_q != 3'h7)
            calm_q <= calm_q + 3'h1;
    end

    a_finit_clear: assert property (!full_init_n_i [*6] |-> read_data_out_o == '0)
        else $error("output not cleared by full init");
    a_finit_flags: assert property (!full_init_n_i [*6] |-> empty_or_output_ready_o == mode_q
        && full_or_input_ready_o != mode_q && !almost_empty_n_o)
        else $error("flags wrong during full init");
    a_pinit_clear: assert property (!partial_init_n_i [*6] |-> read_data_out_o == '0
        && empty_or_output_ready_o == mode_q && !almost_empty_n_o)
        else $error("partial init did not clear");
    a_oe_follow: assert property (($stable(output_enable_n_i)) [*4]
        |-> read_data_out_oe_o == !output_enable_n_i)
        else $error("output drive does not follow enable");
    a_half_below_af: assert property (half_full_n_o |-> almost_full_n_o)
        else $error("almost full below half full");
    a_full_mode: assert property (calm_q == 3'h7 && half_full_n_o
        |-> full_or_input_ready_o != mode_q)
        else $error("full flag wrong for mode");
    a_read_quiet: assert property ((!read_clk_i && full_init_n_i && partial_init_n_i) [*6]
        |=> $stable(read_data_out_o))
        else $error("read data moved without read clock");
    a_flags_quiet: assert property ((!read_clk_i && !write_clk_i && full_init_n_i
        && partial_init_n_i) [*6] |=> $stable({empty_or_output_ready_o, almost_empty_n_o}))
        else $error("flags moved without any clock");
endmodule : dcf_fifo_chk

bind dcf_fifo dcf_fifo_chk dcf_fifo_chk_i (.ref_clk_i, .rstn_i, .write_clk_i, .read_clk_i,
    .full_init_n_i, .partial_init_n_i, .output_enable_n_i, .fallthrough_select_serial_in_i,
    .read_data_out_o, .read_data_out_oe_o, .full_or_input_ready_o, .empty_or_output_ready_o,
    .almost_full_n_o, .almost_empty_n_o, .half_full_n_o);

`default_nettype wire

// >>> dcf_partner.sv
`timescale 1ns/1ps
`include "dcf_regs.svh"
`default_nettype none

// pin clocks idle low; each phase lasts 4 ref cycles
// serial_in_o doubles as the fall-through select pin; set_si drives it for full init and shift drives it with each serial bit
module dcf_partner (
    input  wire logic                   ref_clk_i,
    output logic                        write_clk_o,
    output logic                        read_clk_o,
    output logic                        write_enable_n_o,
    output logic                        read_enable_n_o,
    output logic                        serial_enable_n_o,
    output logic                        serial_in_o,
    output logic      [`DCF_DATA_W-1:0] write_data_o
);
    initial begin
        write_clk_o = 1'b0;
        read_clk_o = 1'b0;
        write_enable_n_o = 1'b1;
        read_enable_n_o = 1'b1;
        serial_enable_n_o = 1'b1;
        serial_in_o = 1'b0;
        write_data_o = '0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : hold

    task automatic wpulse();
        hold(4);
        write_clk_o <= 1'b1;
        hold(4);
        write_clk_o <= 1'b0;
    endtask : wpulse

    task automatic rtog(input int n);
        repeat (n) begin
            hold(4);
            read_clk_o <= ~read_clk_o;
        end
    endtask : rtog

    task automatic push(input logic [`DCF_DATA_W-1:0] d);
        write_enable_n_o <= 1'b0;
        write_data_o <= d;
        wpulse();
        write_enable_n_o <= 1'b1;
        // a released bus shows the inverse, never a stale copy
        write_data_o <= ~d;
        hold(1);
    endtask : push

    task automatic shift(input logic b);
        serial_enable_n_o <= 1'b0;
        serial_in_o <= b;
        wpulse();
        serial_enable_n_o <= 1'b1;
        hold(1);
    endtask : shift

    task automatic pop();
        read_enable_n_o <= 1'b0;
        rtog(2);
        read_enable_n_o <= 1'b1;
        hold(1);
    endtask : pop

    task automatic set_si(input logic b);
        serial_in_o <= b;
    endtask : set_si
endmodule : dcf_partner

`default_nettype wire

// >>> dcf_pkg.sv
package dcf_pkg;
    typedef enum logic {
        DCF_STANDARD    = 1'b0,
        DCF_FALLTHROUGH = 1'b1
    } dcf_mode_e;

    typedef enum logic {
        DCF_PARALLEL = 1'b0,
        DCF_SERIAL   = 1'b1
    } dcf_prog_e;
endpackage : dcf_pkg

// >>> dcf_regs.svh
`ifndef DCF_REGS_SVH
`define DCF_REGS_SVH

`define DCF_DATA_W     9
`define DCF_ADDR_W     16
`define DCF_PTR_W      17
`define DCF_DEPTH      17'h10000
`define DCF_HALF       17'h08000
`define DCF_OFF_W      16
`define DCF_OFF_LOW    16'h007f
`define DCF_OFF_HIGH   16'h03ff
`define DCF_FALL_TRANS 2'h3
`define DCF_SYNC_W     20
`define DCF_SYNC_RST   20'h3de00

`endif

// >>> tb.sv
`timescale 1ns/1ps
`include "dcf_regs.svh"
`default_nettype none

module tb;
    logic ref_clk_i, rstn_i, full_init_n_i, partial_init_n_i, replay_request_n_i;
    logic offset_load_n_i, output_enable_n_i, write_clk_i, read_clk_i, write_enable_n_i;
    logic read_enable_n_i, serial_enable_n_i, fallthrough_select_serial_in_i;
    logic read_data_out_oe_o, full_or_input_ready_o, empty_or_output_ready_o;
    logic almost_full_n_o, almost_empty_n_o, half_full_n_o;
    logic [`DCF_DATA_W-1:0] write_data_in_i, read_data_out_o, w;
    logic [`DCF_DATA_W-1:0] q[$];
    logic [31:0]            sv;
    int                     n_fail, checked, cyc, seed;

    dcf_fifo dcf_fifo_i (.ref_clk_i, .rstn_i, .write_clk_i, .read_clk_i, .write_enable_n_i,
        .read_enable_n_i, .serial_enable_n_i, .offset_load_n_i, .fallthrough_select_serial_in_i,
        .full_init_n_i, .partial_init_n_i, .replay_request_n_i, .output_enable_n_i,
        .write_data_in_i, .read_data_out_o, .read_data_out_oe_o, .full_or_input_ready_o,
        .empty_or_output_ready_o, .almost_full_n_o, .almost_empty_n_o, .half_full_n_o);
    dcf_partner dcf_partner_i (.ref_clk_i, .write_clk_o(write_clk_i), .read_clk_o(read_clk_i),
        .write_enable_n_o(write_enable_n_i), .read_enable_n_o(read_enable_n_i),
        .serial_enable_n_o(serial_enable_n_i), .serial_in_o(fallthrough_select_serial_in_i),
        .write_data_o(write_data_in_i));

    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : hold

    task automatic check(input string what, input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic exp_ae(input int cnt, n);
        return cnt >= n;
    endfunction : exp_ae

    function automatic logic [8:0] part(input logic [15:0] v, input bit hi);
        return hi ? {2'h0, v[15:9]} : v[8:0];
    endfunction : part

    // offsets go empty low, empty high, full low, full high
    task automatic offs(input bit rd, input logic [15:0] n, m);
        offset_load_n_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (rd) begin
                dcf_partner_i.pop();
                check("offset", read_data_out_o, part(i < 2 ? n : m, i[0]));
            end else
                dcf_partner_i.push(part(i < 2 ? n : m, i[0]));
        end
        offset_load_n_i <= 1'b1;
        hold(2);
    endtask : offs

    task automatic finit(input logic ft, ld);
        full_init_n_i <= 1'b0;
        offset_load_n_i <= ld;
        dcf_partner_i.set_si(ft);
        hold(6);
        full_init_n_i <= 1'b1;
        offset_load_n_i <= 1'b1;
        hold(4);
    endtask : finit

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            test_done();
        end
    end

    initial begin
        rstn_i = 1'b0;
        full_init_n_i = 1'b1;
        partial_init_n_i = 1'b1;
        replay_request_n_i = 1'b1;
        offset_load_n_i = 1'b1;
        output_enable_n_i = 1'b1;
        seed = $urandom(32'h7fbfaa3a);
        hold(8);
        rstn_i <= 1'b1;
        hold(3);
        finit(1'b0, 1'b0);
        check("empty", empty_or_output_ready_o, 1'h0);
        check("full", full_or_input_ready_o, 1'h1);
        check("half", half_full_n_o, 1'h1);
        check("afull", almost_full_n_o, 1'h1);
        offs(1'b1, 16'h007f, 16'h007f);
        dcf_partner_i.pop();
        check("data", read_data_out_o, 9'h000);
        for (int i = 0; i < 130; i++) begin
            w = 9'($urandom);
            q.push_back(w);
            output_enable_n_i <= 1'($urandom);
            dcf_partner_i.push(w);
            hold(2);
            check("aempty", almost_empty_n_o, exp_ae(i + 1, 127));
            check("oe", read_data_out_oe_o, !output_enable_n_i);
        end
        check("empty", empty_or_output_ready_o, 1'h1);
        repeat (3) dcf_partner_i.pop();
        check("data", read_data_out_o, q[2]);
        replay_request_n_i <= 1'b0;
        dcf_partner_i.rtog(2);
        replay_request_n_i <= 1'b1;
        check("empty", empty_or_output_ready_o, 1'h0);
        dcf_partner_i.rtog(2);
        hold(2);
        check("empty", empty_or_output_ready_o, 1'h1);
        foreach (q[i]) begin
            dcf_partner_i.pop();
            check("data", read_data_out_o, q[i]);
        end
        check("empty", empty_or_output_ready_o, 1'h0);
        dcf_partner_i.pop();
        check("data", read_data_out_o, q[129]);
        offs(1'b0, 16'h0003, 16'h007f);
        offs(1'b1, 16'h0003, 16'h007f);
        check("empty", empty_or_output_ready_o, 1'h0);
        for (int j = 0; j < 3; j++) begin
            dcf_partner_i.push(9'($urandom));
            hold(2);
            check("aempty", almost_empty_n_o, exp_ae(j + 1, 3));
        end
        partial_init_n_i <= 1'b0;
        hold(6);
        partial_init_n_i <= 1'b1;
        hold(4);
        check("aempty", almost_empty_n_o, 1'h0);
        offs(1'b1, 16'h0003, 16'h007f);
        finit(1'b1, 1'b1);
        check("ready", empty_or_output_ready_o, 1'h1);
        check("space", full_or_input_ready_o, 1'h0);
        w = 9'($urandom);
        dcf_partner_i.push(w);
        dcf_partner_i.rtog(3);
        hold(5);
        check("ready", empty_or_output_ready_o, 1'h0);
        check("data", read_data_out_o, w);
        dcf_partner_i.rtog(1);
        offs(1'b1, 16'h03ff, 16'h03ff);
        sv = {6'h00, 10'($urandom), 16'h0005};
        offset_load_n_i <= 1'b0;
        for (int b = 0; b < 32; b++)
            dcf_partner_i.shift(sv[b]);
        offset_load_n_i <= 1'b1;
        hold(2);
        offs(1'b1, sv[15:0], sv[31:16]);
        test_done();
    end
endmodule : tb

`default_nettype wire
